// File: verilog/sfr_pkg.sv
// Package of constants for the serial flash continuous read front end
package sfr_pkg;
    // ============================================================
    // Command opcodes
    localparam logic [7:0] OPC_READ_LEGACY = 8'hE8; // Four ignored bytes
    localparam logic [7:0] OPC_READ_FAST = 8'h0B;   // One dummy byte
    localparam logic [7:0] OPC_READ_SLOW = 8'h03;   // No dummy byte

    // ============================================================
    // Header framing, counted in serial clock rising edges
    localparam logic [6:0] HDR_OPC_END = 7'h08;   // Opcode complete
    localparam logic [6:0] HDR_ADDR_END = 7'h20;  // Three address bytes done
    localparam logic [6:0] HDR_FAST_END = 7'h28;  // Plus one dummy byte
    localparam logic [6:0] HDR_LEGACY_END = 7'h40; // Plus four ignored bytes

    // ============================================================
    // Address field layout
    localparam int PAGE_W = 13;                  // Page number width
    localparam int BYTE_W = 10;                  // Byte offset width, widest mode
    localparam int PAGE_LSB_528 = 10;            // Page field start, 528 mode
    localparam int PAGE_LSB_512 = 9;             // Page field start, 512 mode
    localparam logic [9:0] LAST_BYTE_528 = 10'h20F; // Last byte of a 528 page
    localparam logic [9:0] LAST_BYTE_512 = 10'h1FF; // Last byte of a 512 page
    localparam logic [12:0] LAST_PAGE = 13'h1FFF;   // Last page of the array

    // ============================================================
    // Host clock limits, for reference by the surrounding system
    localparam int FAST_READ_CLOCK_LIMIT_MHZ = 66; // Legacy and fast opcodes
    localparam int SLOW_READ_CLOCK_LIMIT_MHZ = 33; // Slow opcode

    // ============================================================
    // Front end states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,  // Deselected
        ST_OPC = 6'h02,   // Shifting opcode
        ST_ADDR = 6'h04,  // Shifting address bytes
        ST_DUMMY = 6'h08, // Shifting dummy or ignored bytes
        ST_DATA = 6'h10,  // Streaming array data
        ST_SKIP = 6'h20   // Unsupported opcode, wait for deselect
    } sfr_state_e;
endpackage

// File: verilog/sfr_addr_ctr.sv
// Array address counter with page split, page crossover and array wrap
module sfr_addr_ctr
    import sfr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic page_512,
    input wire logic load,
    input wire logic [23:0] addr_field,
    input wire logic adv,
    output logic [12:0] page_number,
    output logic [9:0] byte_in_page
);
    // ============================================================
    // Field split
    logic [12:0] ld_page; // Page taken from the address field
    logic [9:0] ld_byte;  // Byte taken from the address field
    logic [9:0] last_byte; // Last byte of a page in this mode
    logic at_last;         // Counter sits on the page end

    // 528 mode drops bit 23, 512 mode drops bits 23:22
    assign ld_page = page_512 ? addr_field[21:9] : addr_field[22:10]; // [R05] [R06] [R07] [R22]
    assign ld_byte = page_512 ? {1'b0, addr_field[8:0]} : addr_field[9:0]; // [R03] [R04]
    assign last_byte = page_512 ? LAST_BYTE_512 : LAST_BYTE_528;
    assign at_last = (byte_in_page >= last_byte);

    // ============================================================
    // Counter registers
    // Load wins over advance; whole pages step as a unit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_number <= 13'h0000;
            byte_in_page <= 10'h000;
        end else if (load) begin
            page_number <= ld_page;
            byte_in_page <= ld_byte;
        end else if (adv) begin // [R11]
            if (at_last) begin
                // Next page with no pause, last page wraps to zero
                byte_in_page <= 10'h000; // [R12] [R19]
                page_number <= page_number + 13'h0001; // [R13]
            end else begin
                byte_in_page <= byte_in_page + 10'h001;
            end
        end
    end

    // ============================================================
    // Checks
    property p_cross;
        @(posedge core_clk) disable iff (!rst_n)
        (adv && !load && at_last && page_number != LAST_PAGE)
            |=> (byte_in_page == 10'h000 && page_number == $past(page_number) + 13'h0001);
    endproperty
    a_cross: assert property (p_cross) else $error("Page crossover wrong"); // [R12]

    property p_wrap;
        @(posedge core_clk) disable iff (!rst_n)
        (adv && !load && at_last && page_number == LAST_PAGE)
            |=> (byte_in_page == 10'h000 && page_number == 13'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Array wrap wrong"); // [R13]

    property p_load512;
        @(posedge core_clk) disable iff (!rst_n)
        (load && page_512) |=> (page_number == $past(addr_field[21:9])
            && byte_in_page == {1'b0, $past(addr_field[8:0])});
    endproperty
    a_load512: assert property (p_load512) else $error("512 split wrong"); // [R07]

    property p_load528;
        @(posedge core_clk) disable iff (!rst_n)
        (load && !page_512) |=> (page_number == $past(addr_field[22:10])
            && byte_in_page == $past(addr_field[9:0]));
    endproperty
    a_load528: assert property (p_load528) else $error("528 split wrong"); // [R06]
endmodule

// File: verilog/sfr_out_shift.sv
// Serial output shifter, MSB first, changing on serial clock falls
module sfr_out_shift
    import sfr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic active,
    input wire logic sck_fall,
    input wire logic [7:0] next_byte,
    output logic so_bit,
    output logic need_fetch
);
    // ============================================================
    // State
    logic [7:0] shreg_r;  // Remaining bits of current byte
    logic [2:0] bit_cnt_r; // Bits sent of current byte
    logic byte_start;      // This fall opens a new byte

    assign byte_start = active && sck_fall && (bit_cnt_r == 3'h0);

    // ============================================================
    // Shift on each fall; a fresh byte asks for the next one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            so_bit <= 1'b0;
            need_fetch <= 1'b0;
        end else if (!active) begin
            // Idle between streams
            bit_cnt_r <= 3'h0;
            need_fetch <= 1'b0;
        end else begin
            need_fetch <= byte_start;
            if (sck_fall) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (byte_start) begin
                    so_bit <= next_byte[7]; // [R02] [R21]
                    shreg_r <= {next_byte[6:0], 1'b0};
                end else begin
                    so_bit <= shreg_r[7]; // [R21]
                    shreg_r <= {shreg_r[6:0], 1'b0};
                end
            end
        end
    end

    // ============================================================
    // Checks
    property p_msb_first;
        @(posedge core_clk) disable iff (!rst_n)
        byte_start |=> (so_bit == $past(next_byte[7]) && need_fetch);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Byte not MSB first"); // [R02]

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (!sck_fall) |=> $stable(so_bit);
    endproperty
    a_hold: assert property (p_hold) else $error("Output moved without fall"); // [R21]
endmodule

// File: verilog/sfr_top.sv
// Serial flash command front end and continuous array read path
// Summary of operation
// [R01] Chip select fall, opcode, then address
// [R02] All fields shifted most significant bit first
// [R03] 528 mode: 13-bit page, 10-bit byte
// [R04] Buffer offset is 10 or 9 bits
// [R05] 512 mode: 22-bit address, page over byte
// [R06] 528 mode split of 23-bit field
// [R07] 512 mode split of 22-bit field
// [R08] Legacy read: four ignored bytes before data
// [R09] Fast read: one dummy byte before data
// [R10] Slow read: data right after address
// [R11] Address counter advances itself during stream
// [R12] Page end crosses to next page seamlessly
// [R13] Array end wraps to first page seamlessly
// [R14] Host holds chip select low throughout
// [R15] Chip select rise ends read, output floats
// [R16] Array reads never touch data buffers
// [R17] Host keeps clock within per-opcode limits
// [R18] Serial modes 0 and 3 supported
// [R19] Array organised in whole pages
// [R20] Input bits captured on clock rise
// [R21] Output bits change on clock fall
// [R22] Unused leading address bits are ignored
module sfr_top
    import sfr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic page_512,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe_n,
    output logic [12:0] array_page,
    output logic [9:0] array_byte,
    output logic array_rd,
    input wire logic [7:0] array_rdata
);
    // ============================================================
    // Reset release
    logic [1:0] rst_sync_r; // Two-stage release chain
    logic rst_n;            // Released reset for the design

    // Assert at once, release after two edges
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ============================================================
    // Pin edge detection
    logic sck_q_r;  // Serial clock one cycle ago
    logic cs_n_q_r; // Chip select one cycle ago
    logic sck_rise; // Serial clock rising while selected
    logic sck_fall; // Serial clock falling while selected
    logic cs_rise;  // Deselect event

    // Previous pin levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q_r <= 1'b0;
            cs_n_q_r <= 1'b1;
        end else begin
            sck_q_r <= sck;
            cs_n_q_r <= cs_n;
        end
    end
    assign sck_rise = !cs_n && sck && !sck_q_r; // [R20]
    assign sck_fall = !cs_n && !sck && sck_q_r; // [R21]
    assign cs_rise = cs_n && !cs_n_q_r;

    // ============================================================
    // Header shifting
    sfr_state_e state_r;  // Front end state
    sfr_state_e state_nxt;
    logic [31:0] in_sr_r; // Opcode and address shift register
    logic [31:0] in_sr_nxt;
    logic [6:0] hdr_cnt_r; // Rising edges since selection
    logic [6:0] hdr_cnt_nxt;
    logic [7:0] opcode_r;  // Captured opcode
    logic [6:0] hdr_end;   // Header length of the captured opcode
    logic opc_ok;          // New opcode is a supported read
    logic addr_load;       // Address field complete
    logic go_data;         // Header complete, stream begins

    // New bit enters at the bottom, so the first bit ends on top
    assign in_sr_nxt = {in_sr_r[30:0], si}; // [R02]
    assign hdr_cnt_nxt = hdr_cnt_r + 7'h01;
    assign opc_ok = (in_sr_nxt[7:0] == OPC_READ_LEGACY) || (in_sr_nxt[7:0] == OPC_READ_FAST)
        || (in_sr_nxt[7:0] == OPC_READ_SLOW);
    // Dummy length follows the opcode
    assign hdr_end = (opcode_r == OPC_READ_LEGACY) ? HDR_LEGACY_END : // [R08]
        (opcode_r == OPC_READ_FAST) ? HDR_FAST_END : HDR_ADDR_END; // [R09] [R10]
    assign addr_load = (state_r == ST_ADDR) && sck_rise && (hdr_cnt_nxt == HDR_ADDR_END);
    assign go_data = sck_rise && (hdr_cnt_nxt == hdr_end)
        && ((state_r == ST_ADDR) || (state_r == ST_DUMMY));

    // Next state; deselect always returns to idle
    always_comb begin
        state_nxt = state_r;
        if (cs_n) begin
            state_nxt = ST_IDLE; // [R15]
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_OPC; // [R01]
                end
                ST_OPC: begin
                    if (sck_rise && hdr_cnt_nxt == HDR_OPC_END) begin
                        state_nxt = opc_ok ? ST_ADDR : ST_SKIP;
                    end
                end
                ST_ADDR, ST_DUMMY: begin
                    if (go_data) begin
                        state_nxt = ST_DATA;
                    end else if (addr_load) begin
                        state_nxt = ST_DUMMY;
                    end
                end
                ST_DATA: begin
                    state_nxt = ST_DATA;
                end
                ST_SKIP: begin
                    state_nxt = ST_SKIP;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // State and header registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            in_sr_r <= 32'h0000_0000;
            hdr_cnt_r <= 7'h00;
            opcode_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE) begin
                hdr_cnt_r <= 7'h00; // [R01]
            end else if (sck_rise && state_r != ST_DATA && state_r != ST_SKIP) begin
                in_sr_r <= in_sr_nxt; // [R20]
                hdr_cnt_r <= hdr_cnt_nxt;
                if (state_r == ST_OPC && hdr_cnt_nxt == HDR_OPC_END) begin
                    opcode_r <= in_sr_nxt[7:0];
                end
            end
        end
    end

    // ============================================================
    // Array fetch and output stream
    logic [7:0] next_byte_r; // Prefetched array byte
    logic start_fetch_r;     // First fetch, one cycle after the header completes (go_data)
    logic need_fetch;        // Shifter consumed the prefetched byte
    logic so_bit;            // Shifter output bit
    logic in_data;           // Stream phase

    assign in_data = (state_r == ST_DATA);

    // Fetch strobe; the array is read directly, no buffer is written
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_fetch_r <= 1'b0;
            array_rd <= 1'b0;
            next_byte_r <= 8'h00;
        end else begin
            start_fetch_r <= go_data && !cs_n;
            array_rd <= (start_fetch_r || need_fetch) && !cs_n; // [R16]
            if (array_rd) begin
                next_byte_r <= array_rdata;
            end
        end
    end

    // Address counter; each fetch advances it
    sfr_addr_ctr u_addr_ctr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .page_512(page_512),
        .load(addr_load),
        .addr_field(in_sr_nxt[23:0]),
        .adv(array_rd), // [R11]
        .page_number(array_page),
        .byte_in_page(array_byte)
    );

    // Output shifter
    sfr_out_shift u_out_shift (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .active(in_data),
        .sck_fall(sck_fall),
        .next_byte(next_byte_r),
        .so_bit(so_bit),
        .need_fetch(need_fetch)
    );

    // Pin drivers; enable opens on first fall, closes on deselect
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_out <= so_bit;
            if (cs_n || !in_data) begin
                so_oe_n <= 1'b1; // [R15]
            end else if (sck_fall) begin
                so_oe_n <= 1'b0; // [R18]
            end
        end
    end

    // ============================================================
    // Checks
    property p_deselect;
        @(posedge core_clk) disable iff (!rst_n)
        cs_rise |=> (so_oe_n && state_r == ST_IDLE);
    endproperty
    a_deselect: assert property (p_deselect) else $error("Deselect left output on"); // [R15]

    property p_drive_only_data;
        @(posedge core_clk) disable iff (!rst_n)
        !so_oe_n |-> ($past(state_r) == ST_DATA);
    endproperty
    a_drive_only_data: assert property (p_drive_only_data) else $error("Output early"); // [R08]

    property p_slow_start;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_load && opcode_r == OPC_READ_SLOW && !cs_n)
            |=> (state_r == ST_DATA && start_fetch_r);
    endproperty
    a_slow_start: assert property (p_slow_start) else $error("Slow read did not start"); // [R10]

    property p_fast_dummy;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_load && opcode_r == OPC_READ_FAST && !cs_n) |=> (state_r == ST_DUMMY);
    endproperty
    a_fast_dummy: assert property (p_fast_dummy) else $error("Fast read skipped dummy"); // [R09]

    property p_opcode_end;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_OPC && sck_rise && hdr_cnt_r == 7'h07 && !cs_n) |=> (state_r != ST_OPC);
    endproperty
    a_opcode_end: assert property (p_opcode_end) else $error("Opcode not 8 bits"); // [R01]

    property p_fetch_follows;
        @(posedge core_clk) disable iff (!rst_n)
        (need_fetch && !cs_n) |=> array_rd;
    endproperty
    a_fetch_follows: assert property (p_fetch_follows) else $error("Byte not fetched"); // [R11]

    // Header bit lands at the bottom of the shifter on a rise
    property p_capture_rise;
        @(posedge core_clk) disable iff (!rst_n)
        (sck_rise && (state_r == ST_OPC || state_r == ST_ADDR || state_r == ST_DUMMY))
            |=> (in_sr_r[0] == $past(si));
    endproperty
    a_capture_rise: assert property (p_capture_rise) else $error("Input bit not taken"); // [R20]

    // Header shifter only moves on a serial clock rise
    property p_in_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (!sck_rise) |=> $stable(in_sr_r);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("Input moved without rise"); // [R20]

    // Legacy opcode waits through its ignored bytes
    property p_legacy_wait;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_load && opcode_r == OPC_READ_LEGACY && !cs_n) |=> (state_r == ST_DUMMY);
    endproperty
    a_legacy_wait: assert property (p_legacy_wait) else $error("Legacy read skipped bytes"); // [R08]

    // Dummy phase ends exactly at the header length
    property p_dummy_end;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_DUMMY && sck_rise && hdr_cnt_nxt == hdr_end) |=> (state_r == ST_DATA);
    endproperty
    a_dummy_end: assert property (p_dummy_end) else $error("Data phase late"); // [R09]

    // Opcode register takes the eighth bit's byte
    property p_opc_capture;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_OPC && sck_rise && hdr_cnt_nxt == HDR_OPC_END)
            |=> (opcode_r == $past(in_sr_nxt[7:0]));
    endproperty
    a_opc_capture: assert property (p_opc_capture) else $error("Opcode not captured"); // [R01]

    // Refused opcode keeps the output off
    property p_skip_silent;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_SKIP) |-> so_oe_n;
    endproperty
    a_skip_silent: assert property (p_skip_silent) else $error("Refused opcode drove"); // [R01]

    // Array fetch strobe lasts one cycle
    property p_rd_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        array_rd |=> !array_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("Fetch strobe too long"); // [R11]

    // Deselected level floats the output next edge
    property p_cs_float;
        @(posedge core_clk) disable iff (!rst_n)
        cs_n |=> so_oe_n;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("Output on while deselected"); // [R15]
endmodule

// File: tb/sfr_host_model.sv
// Host side serial master model driving the flash front end
module sfr_host_model (
    input wire logic core_clk,
    input wire logic so_out,
    input wire logic so_oe_n,
    output logic cs_n,
    output logic sck,
    output logic si
);
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Idle levels at time zero
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // ============================================================
    // Framing tasks

    // Idle clock level picks the serial mode, then select
    task automatic select(input logic mode3);
        @(posedge core_clk);
        sck <= mode3;
        repeat (2) @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // One byte each way, eight core cycles per clock period
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic [1:0] oe_seen);
        int i;
        oe_seen = 2'b00;
        rx = 8'h00;
        for (i = 7; i >= 0; i--) begin
            // Data set with the fall, steady across the rise
            @(posedge core_clk);
            si <= tx[i];
            sck <= 1'b0;
            repeat (4) @(posedge core_clk);
            // Output sampled where the rise is launched
            rx[i] = so_out;
            oe_seen = oe_seen | {so_oe_n, ~so_oe_n};
            sck <= 1'b1;
            repeat (3) @(posedge core_clk);
        end
    endtask

    // Return clock to idle, then deselect
    task automatic deselect(input logic mode3);
        if (!mode3) begin
            @(posedge core_clk);
            sck <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        @(posedge core_clk);
        // Chip select held low until here
        cs_n <= 1'b1;
        si <= ~si;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the serial flash continuous read front end
module testbench
    import sfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Signals
    logic core_clk; // Core clock
    logic reset_n; // Active low reset
    logic page_512; // Page size select
    logic cs_n; // Chip select from host
    logic sck; // Serial clock from host
    logic si; // Serial data from host
    logic so_out; // Serial data to host
    logic so_oe_n; // Output enable, low drives
    logic [12:0] array_page; // Array page requested
    logic [9:0] array_byte; // Array byte requested
    logic array_rd; // Array fetch strobe
    logic [7:0] array_rdata; // Array data returned
    int fail_count = 0; // Mismatches
    int comparisons = 0; // Compares made

    // ============================================================
    // Array content pattern, distinct across page edges
    function automatic logic [7:0] pat(input logic [12:0] p, input logic [9:0] b);
        return b[7:0] ^ {p[5:0], b[9:8]};
    endfunction

    assign array_rdata = pat(array_page, array_byte);

    // ============================================================
    // Instances
    sfr_top uut (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .page_512(page_512),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .so_out(so_out),
        .so_oe_n(so_oe_n),
        .array_page(array_page),
        .array_byte(array_byte),
        .array_rd(array_rd),
        .array_rdata(array_rdata)
    );

    sfr_host_model host (
        .core_clk(core_clk),
        .so_out(so_out),
        .so_oe_n(so_oe_n),
        .cs_n(cs_n),
        .sck(sck),
        .si(si)
    );

    // ============================================================
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ============================================================
    // Checking and closing
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ============================================================
    // Shared read command: header, stream compare, deselect
    task automatic rd_cmd(input logic [7:0] opc, input logic m3, input logic p512,
        input logic [12:0] pg, input logic [9:0] by, input int ndum, input int n);
        logic [23:0] a;
        logic [7:0] rx;
        logic [1:0] oe;
        logic [12:0] p;
        logic [9:0] b;
        int k;
        // Unused leading address bits set to one
        a = p512 ? {2'b11, pg, by[8:0]} : {1'b1, pg, by};
        @(posedge core_clk);
        page_512 <= p512;
        host.select(m3);
        host.xfer(opc, rx, oe);
        for (k = 0; k < 3; k++) begin
            host.xfer(a[23 - 8 * k -: 8], rx, oe);
        end
        for (k = 0; k < ndum; k++) begin
            host.xfer(8'hC3, rx, oe);
        end
        p = pg;
        b = by;
        for (k = 0; k < n; k++) begin
            host.xfer(8'h3C, rx, oe);
            chk({14'h0000, oe}, 16'h0001);
            chk({8'h00, rx}, {8'h00, pat(p, b)});
            // Expected address step with page crossover and wrap
            if (b == (p512 ? LAST_BYTE_512 : LAST_BYTE_528)) begin
                b = 10'h000;
                p = p + 13'h0001;
            end else begin
                b = b + 10'h001;
            end
        end
        host.deselect(m3);
        repeat (2) @(posedge core_clk);
        chk({15'h0000, so_oe_n}, 16'h0001);
    endtask

    // ============================================================
    // Scenarios

    // Slow read, 528 page, crosses into next page
    task automatic t_slow_528_cross;
        rd_cmd(OPC_READ_SLOW, 1'b0, 1'b0, 13'h0005, 10'h20E, 0, 4);
    endtask

    // Fast read, 512 page, wraps from array end
    task automatic t_fast_512_wrap;
        rd_cmd(OPC_READ_FAST, 1'b0, 1'b1, 13'h1FFF, 10'h1FE, 1, 3);
    endtask

    // Legacy read in mode 3, 528 page, wraps from array end
    task automatic t_legacy_m3_wrap;
        rd_cmd(OPC_READ_LEGACY, 1'b1, 1'b0, 13'h1FFF, 10'h20F, 4, 2);
    endtask

    // Legacy read, 512 page, crosses mid-array page edge
    task automatic t_legacy_512_cross;
        rd_cmd(OPC_READ_LEGACY, 1'b0, 1'b1, 13'h0ABC, 10'h1FF, 4, 2);
    endtask

    // Unsupported opcode never enables the output
    task automatic t_refused;
        logic [7:0] rx;
        logic [1:0] oe;
        int k;
        host.select(1'b0);
        host.xfer(8'hD2, rx, oe);
        for (k = 0; k < 4; k++) begin
            host.xfer(8'h00, rx, oe);
            chk({14'h0000, oe}, 16'h0002);
        end
        host.deselect(1'b0);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        page_512 = 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_refused;
        t_slow_528_cross;
        t_fast_512_wrap;
        t_legacy_m3_wrap;
        t_legacy_512_cross;
        close_out;
    end

    // ============================================================
    // Watchdog, well beyond the expected run length
    initial begin
        repeat (30000) @(posedge core_clk);
        fail_count++;
        close_out;
    end
endmodule
